/* File: design/ssr_cfg.svh */
// Bit positions, reset values and widths for the status summary block
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

`define SSR_POS_IDLE        3'd7
`define SSR_POS_REQ         3'd6
`define SSR_POS_EVSUM       3'd5
`define SSR_POS_OUTPEND     3'd4
`define SSR_POS_ERRPEND     3'd3
`define SSR_POS_CHGSUM      3'd2
`define SSR_POS_MALFORMED   3'd5

`define SSR_SRC_LO          2
`define SSR_SRC_HI          5

`define SSR_REQ_MASK_RESET  8'h00
`define SSR_EVT_MASK_RESET  8'h00
`define SSR_EVT_LATCH_RESET 8'h00
`define SSR_REQ_MASK_USED   8'h3c
`define SSR_ZERO_BYTE       8'h00

`endif

/* File: design/ssr_pkg.sv */
// Types and shared decode for the status summary block
package ssr_pkg;

    typedef logic [7:0]  ssr_byte_t;
    typedef logic [15:0] ssr_word_t;

    typedef enum logic [2:0] {
        SSR_Q_NONE    = 3'b000,
        SSR_Q_POLL    = 3'b001,
        SSR_Q_STATUS  = 3'b010,
        SSR_Q_LATCH   = 3'b011,
        SSR_Q_EVMASK  = 3'b100,
        SSR_Q_RQMASK  = 3'b101,
        SSR_Q_STATE   = 3'b110
    } ssr_query_t;

    // Summary of a flag vector gated by its enable vector
    function automatic logic ssr_any_enabled(input ssr_word_t flags, input ssr_word_t enables);
        return |(flags & enables);
    endfunction

endpackage

/* File: design/ssr_evt_if.sv */
// Signals between the status top and its event latch
`timescale 1ns/1ps
interface ssr_evt_if;
    import ssr_pkg::*;
    ssr_byte_t eventSet;
    logic      clearLatch;
    logic      maskWrite;
    ssr_byte_t maskData;
    ssr_byte_t latch;
    ssr_byte_t mask;
    logic      summary;

    modport owner (
        output eventSet,
        output clearLatch,
        output maskWrite,
        output maskData,
        input  latch,
        input  mask,
        input  summary
    );
    modport keeper (
        input  eventSet,
        input  clearLatch,
        input  maskWrite,
        input  maskData,
        output latch,
        output mask,
        output summary
    );
endinterface

/* File: design/ssr_event_latch.sv */
// Sticky event latch with its enable mask and summary
`timescale 1ns/1ps
`include "ssr_cfg.svh"
module ssr_event_latch (
    input wire logic core_clk,
    input wire logic srst,
    ssr_evt_if.keeper evt
);
    import ssr_pkg::*;

    ssr_byte_t latch;
    ssr_byte_t mask;

    // Set wins over clear so an event in the clearing cycle survives
    always_ff @(posedge core_clk) begin
        if (srst) begin
            latch <= `SSR_EVT_LATCH_RESET;
        end else if (evt.clearLatch) begin
            latch <= evt.eventSet;
        end else begin
            latch <= latch | evt.eventSet;
        end
    end

    // Reading the mask has no side effect; only a write changes it
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mask <= `SSR_EVT_MASK_RESET;
        end else if (evt.maskWrite) begin
            mask <= evt.maskData;
        end
    end

    assign evt.latch   = latch;
    assign evt.mask    = mask;
    assign evt.summary = ssr_any_enabled({8'h00, latch}, {8'h00, mask});

    AST_LATCH_STICKY: assert property (@(posedge core_clk) disable iff (srst)
        !evt.clearLatch |=> ((latch & $past(latch)) == $past(latch)))
        else $error("Event latch bit dropped without a clear");

    AST_LATCH_CLEAR_KEEPS_SET: assert property (@(posedge core_clk) disable iff (srst)
        evt.clearLatch |=> (latch == $past(evt.eventSet)))
        else $error("Clear of event latch lost or kept wrong bits");

    AST_MASK_HOLDS: assert property (@(posedge core_clk) disable iff (srst)
        !evt.maskWrite |=> $stable(mask))
        else $error("Event mask changed without a write");

    AST_MASK_MASKED_BIT_RECORDS: assert property (@(posedge core_clk) disable iff (srst)
        (evt.eventSet != 8'h00 && !evt.clearLatch) |=> ((latch & $past(evt.eventSet)) == $past(evt.eventSet)))
        else $error("Event not recorded in latch");

endmodule // ssr_event_latch

/* File: design/ssr_status_top.sv */
// Status summary byte, request mask and service request generation
//
// Behaviour
// - Reading the event latch returns it, then clears every bit except those set by an event in the same cycle.
// - Reading the event mask leaves it unchanged.
// - Latch and mask reads return an 8-bit value in bits 0 through 7, upper byte reads zero.
// - Summary bit 7 is 1 while the remote interface waits for input.
// - Service request flag sets when an enabled source bit rises 0 to 1.
// - SRQ line is driven asserted while the service request flag is 1.
// - Master summary is OR of enabled sources; status query returns it in bit 6.
// - Bit 5 is 1 when any enabled event latch bit is 1.
// - Bit 4 is 1 while the output buffer holds unread data.
// - Bit 3 is 1 while an error waits in the error queue.
// - Bit 2 is 1 when any enabled state change latch bit is 1.
// - A zero mask bit hides a latch bit from the summary, still recorded.
// - Event latch bit 5 sets on a malformed command.
// - Instrument state word is read only, upper byte reads zero.
// - Controller may write the event mask anytime; it reads back.
// - Serial poll, clear status or master summary falling clears SRQ and flag.
// - Event latch bits stay set until read, device clear, reset or clear status.
// - Request mask clears to zero at power-up.
// - Summary bits 1 and 0 always read 0.
`timescale 1ns/1ps
`include "ssr_cfg.svh"
module ssr_status_top #(
    parameter int EVENT_WIDTH = 8
) (
    input  wire logic              core_clk,
    input  wire logic              srst,
    // Remote command strobes, one cycle each, from the command parser
    input  wire logic              qEventLatch,
    input  wire logic              qEventMask,
    input  wire logic              qRequestMask,
    input  wire logic              qStatusByte,
    input  wire logic              qStateWord,
    input  wire logic              serialPoll,
    input  wire logic              wEventMask,
    input  wire logic              wRequestMask,
    input  wire ssr_pkg::ssr_word_t wData,
    input  wire logic              clearStatus,
    input  wire logic              deviceClear,
    input  wire logic              resetCmd,
    // Instrument conditions, from logic on core_clk
    input  wire logic [EVENT_WIDTH-1:0] eventIn,
    input  wire logic              malformedCmd,
    input  wire logic              remoteIdle,
    input  wire logic              outputPending,
    input  wire logic              errorPending,
    input  wire ssr_pkg::ssr_word_t stateChangeLatch,
    input  wire ssr_pkg::ssr_word_t stateChangeMask,
    input  wire ssr_pkg::ssr_byte_t instrumentState,
    // Answers
    output ssr_pkg::ssr_word_t     respData,
    output logic                   respValid,
    output logic                   serviceRequest,
    output logic                   masterSummary,
    output logic                   srqO,
    output logic                   srqOe
);
    import ssr_pkg::*;

    ssr_evt_if evt ();

    ssr_event_latch u_latch (
        .core_clk (core_clk),
        .srst     (srst),
        .evt      (evt)
    );

    ssr_byte_t  requestMask;
    ssr_byte_t  sources;
    ssr_byte_t  gated;
    ssr_byte_t  prevGated;
    ssr_byte_t  pollByte;
    ssr_byte_t  statusByte;
    logic [`SSR_SRC_HI:`SSR_SRC_LO] rise;
    logic       anyRise;
    logic       next_serviceRequest;
    ssr_query_t query;
    ssr_byte_t  eventSet;

    // Events from the instrument plus the malformed command flag
    always_comb begin
        eventSet = ssr_byte_t'(eventIn);
        eventSet[`SSR_POS_MALFORMED] = eventSet[`SSR_POS_MALFORMED] | malformedCmd;
    end

    assign evt.eventSet   = eventSet;
    // A latch read clears it only when that read is the one being served
    assign evt.clearLatch = (query == SSR_Q_LATCH) | clearStatus | deviceClear | resetCmd;
    assign evt.maskWrite  = wEventMask;
    assign evt.maskData   = wData[7:0];

    // Summary sources; idle sits in bit 7 but never requests service
    always_comb begin
        sources = `SSR_ZERO_BYTE;
        sources[`SSR_POS_IDLE]    = remoteIdle;
        sources[`SSR_POS_EVSUM]   = evt.summary;
        sources[`SSR_POS_OUTPEND] = outputPending;
        sources[`SSR_POS_ERRPEND] = errorPending;
        sources[`SSR_POS_CHGSUM]  = ssr_any_enabled(stateChangeLatch, stateChangeMask);
    end

    assign gated         = sources & requestMask;
    assign masterSummary = |gated[`SSR_SRC_HI:`SSR_SRC_LO];

    always_ff @(posedge core_clk) begin
        if (srst) begin
            requestMask <= `SSR_REQ_MASK_RESET;
        end else if (wRequestMask) begin
            // Only the four source positions can request service
            requestMask <= wData[7:0] & `SSR_REQ_MASK_USED;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            prevGated <= `SSR_ZERO_BYTE;
        end else begin
            prevGated <= gated;
        end
    end

    genvar gi;
    generate
        for (gi = `SSR_SRC_LO; gi <= `SSR_SRC_HI; gi++) begin : g_rise
            assign rise[gi] = gated[gi] & ~prevGated[gi];
        end
    endgenerate
    assign anyRise = |rise;

    // A rise in the same cycle as a poll or clear wins, so no request is lost
    always_comb begin
        next_serviceRequest = serviceRequest;
        if (serialPoll || clearStatus || !masterSummary) begin
            next_serviceRequest = 1'b0;
        end
        if (anyRise) begin
            next_serviceRequest = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            serviceRequest <= 1'b0;
        end else begin
            serviceRequest <= next_serviceRequest;
        end
    end

    // Open-drain SRQ: pull low while requesting, release otherwise
    assign srqO  = 1'b0;
    assign srqOe = serviceRequest;

    // Poll answers carry the request flag, the status query the summary
    always_comb begin
        pollByte = sources;
        pollByte[`SSR_POS_REQ] = serviceRequest;
        pollByte[1:0] = 2'b00;
        statusByte = sources;
        statusByte[`SSR_POS_REQ] = masterSummary;
        statusByte[1:0] = 2'b00;
    end

    // One query is served per cycle; the parser issues them singly
    always_comb begin
        if (serialPoll) begin
            query = SSR_Q_POLL;
        end else if (qStatusByte) begin
            query = SSR_Q_STATUS;
        end else if (qEventLatch) begin
            query = SSR_Q_LATCH;
        end else if (qEventMask) begin
            query = SSR_Q_EVMASK;
        end else if (qRequestMask) begin
            query = SSR_Q_RQMASK;
        end else if (qStateWord) begin
            query = SSR_Q_STATE;
        end else begin
            query = SSR_Q_NONE;
        end
    end

    // The answer is binary; the text formatter turns it into decimal
    always_ff @(posedge core_clk) begin
        if (srst) begin
            respData <= 16'h0000;
        end else begin
            unique case (query)
                SSR_Q_NONE:   respData <= respData;
                SSR_Q_POLL:   respData <= {8'h00, pollByte};
                SSR_Q_STATUS: respData <= {8'h00, statusByte};
                SSR_Q_LATCH:  respData <= {8'h00, evt.latch};
                SSR_Q_EVMASK: respData <= {8'h00, evt.mask};
                SSR_Q_RQMASK: respData <= {8'h00, requestMask};
                SSR_Q_STATE:  respData <= {8'h00, instrumentState};
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            respValid <= 1'b0;
        end else begin
            respValid <= (query != SSR_Q_NONE);
        end
    end

    AST_REQ_SETS_ON_RISE: assert property (@(posedge core_clk) disable iff (srst)
        anyRise |=> serviceRequest)
        else $error("Enabled source rise did not set service request");

    AST_SRQ_FOLLOWS_FLAG: assert property (@(posedge core_clk) disable iff (srst)
        (srqOe == serviceRequest) && (srqO == 1'b0))
        else $error("SRQ drive does not follow service request flag");

    AST_SUMMARY_STATUS_BIT: assert property (@(posedge core_clk) disable iff (srst)
        (query == SSR_Q_STATUS) |=> (respData[6] == $past(masterSummary) && respValid))
        else $error("Status query did not return master summary");

    AST_REQ_CLEARS: assert property (@(posedge core_clk) disable iff (srst)
        ((serialPoll || clearStatus || !masterSummary) && !anyRise) |=> !serviceRequest)
        else $error("Service request not cleared");

    AST_LATCH_READ_CLEARS: assert property (@(posedge core_clk) disable iff (srst)
        (query == SSR_Q_LATCH && eventSet == 8'h00) |=>
            (respData == {8'h00, $past(evt.latch)}) ##0 (evt.latch == 8'h00))
        else $error("Event latch read returned wrong value or did not clear");

    AST_EVSUM_BIT: assert property (@(posedge core_clk) disable iff (srst)
        sources[5] == |(evt.latch & evt.mask))
        else $error("Event summary bit mismatch");

    AST_MALFORMED_SETS: assert property (@(posedge core_clk) disable iff (srst)
        malformedCmd |=> evt.latch[5])
        else $error("Malformed command did not set latch bit 5");

    AST_STATE_UPPER_ZERO: assert property (@(posedge core_clk) disable iff (srst)
        (query == SSR_Q_STATE) |=> (respData[15:8] == 8'h00 && respData[7:0] == $past(instrumentState)))
        else $error("State word answer wrong");

    AST_LOW_BITS_ZERO: assert property (@(posedge core_clk) disable iff (srst)
        (query == SSR_Q_POLL || query == SSR_Q_STATUS) |=> (respData[1:0] == 2'b00))
        else $error("Summary bits 1 and 0 not zero");

    AST_MASK_READBACK: assert property (@(posedge core_clk) disable iff (srst)
        (wEventMask && !serialPoll && !qStatusByte && !qEventLatch) ##1 (query == SSR_Q_EVMASK && !wEventMask)
            |=> (respData[7:0] == $past(evt.maskData, 2)))
        else $error("Event mask did not read back written value");

    AST_MASK_RESET: assert property (@(posedge core_clk)
        $past(srst) |-> (requestMask == 8'h00))
        else $error("Request mask not cleared by reset");

    AST_IDLE_BIT: assert property (@(posedge core_clk) disable iff (srst)
        (query == SSR_Q_POLL) |=> (respData[7] == $past(remoteIdle)))
        else $error("Remote idle bit wrong in poll answer");

    AST_POLL_REQ_BIT: assert property (@(posedge core_clk) disable iff (srst)
        (query == SSR_Q_POLL) |=> (respData[6] == $past(serviceRequest)))
        else $error("Poll answer bit 6 is not the service request flag");

    AST_OUTPEND_BIT: assert property (@(posedge core_clk) disable iff (srst)
        (query == SSR_Q_POLL) |=> (respData[4] == $past(outputPending)))
        else $error("Output pending bit wrong in poll answer");

    AST_ERRPEND_BIT: assert property (@(posedge core_clk) disable iff (srst)
        (query == SSR_Q_POLL) |=> (respData[3] == $past(errorPending)))
        else $error("Error pending bit wrong in poll answer");

    AST_CHGSUM_BIT: assert property (@(posedge core_clk) disable iff (srst)
        sources[2] == |(stateChangeLatch & stateChangeMask))
        else $error("State change summary bit mismatch");

    AST_EVMASK_READ: assert property (@(posedge core_clk) disable iff (srst)
        (query == SSR_Q_EVMASK && !wEventMask) |=> ((respData == {8'h00, $past(evt.mask)}) && $stable(evt.mask)))
        else $error("Event mask read returned wrong value or changed it");

    AST_READ_UPPER_ZERO: assert property (@(posedge core_clk) disable iff (srst)
        (query == SSR_Q_LATCH || query == SSR_Q_EVMASK) |=> (respData[15:8] == 8'h00))
        else $error("Latch or mask answer has upper bits set");

    AST_RESP_VALID: assert property (@(posedge core_clk) disable iff (srst)
        (query != SSR_Q_NONE) |=> respValid)
        else $error("Served query gave no answer strobe");

    AST_RESP_IDLE: assert property (@(posedge core_clk) disable iff (srst)
        (query == SSR_Q_NONE) |=> !respValid)
        else $error("Answer strobe without a query");

    COV_STATUS_WITH_SUMMARY: cover property (@(posedge core_clk) disable iff (srst)
        (query == SSR_Q_STATUS) && masterSummary);

    COV_POLL_WITH_REQUEST: cover property (@(posedge core_clk) disable iff (srst)
        serviceRequest && serialPoll);

    COV_EVENT_DURING_CLEAR: cover property (@(posedge core_clk) disable iff (srst)
        (query == SSR_Q_LATCH) && (eventSet != 8'h00));

    COV_SUMMARY_FALLS: cover property (@(posedge core_clk) disable iff (srst)
        serviceRequest ##1 !masterSummary);

endmodule // ssr_status_top

/* File: sim/ssr_ctrl_model.sv */
// Bus controller model: issues remote command strobes and watches SRQ
`timescale 1ns/1ps
module ssr_ctrl_model (
    input  wire logic          core_clk,
    input  wire logic          srqO,
    input  wire logic          srqOe,
    output logic [10:0]        strobes,
    output ssr_pkg::ssr_word_t wData,
    output wire logic          srqLine
);
    import ssr_pkg::*;
    // SRQ is open drain with a pull-up, so a released line reads high
    assign srqLine = srqOe ? srqO : 1'b1;
    initial begin
        strobes = '0;
        wData   = 16'h0000;
    end
    // A mask write may come at any time; strobes drop for a cycle between calls
    task automatic issue(input logic [10:0] cmds, input ssr_word_t d);
        @(negedge core_clk);
        strobes = cmds;
        wData   = d;
        @(negedge core_clk);
        strobes = '0;
        wData   = ~d;
    endtask
endmodule // ssr_ctrl_model

/* File: sim/tb_top.sv */
// Self-checking bench for the status summary block
`timescale 1ns/1ps
module tb_top;
    import ssr_pkg::*;
    logic        core_clk = 1'b0;
    logic        srst     = 1'b1;
    logic [10:0] cmd;
    ssr_word_t   wData, respData, mData;
    ssr_word_t   stateChangeLatch = 16'h0000, stateChangeMask = 16'h0000;
    ssr_byte_t   eventIn = 8'h00, instrumentState = 8'h00;
    logic        malformedCmd = 1'b0, remoteIdle = 1'b0, outputPending = 1'b0, errorPending = 1'b0;
    logic        respValid, serviceRequest, masterSummary, srqO, srqOe, srqLine;
    ssr_byte_t   mLatch, mEvMask, mRqMask, mPrev;
    logic        mFlag, mValid;
    int          bad_count = 0, check_count = 0, cycles = 0, seed = 32'h417a;
    bit          randOn = 1'b0;

    always #10 core_clk = ~core_clk;

    ssr_status_top #(.EVENT_WIDTH(8)) u_dut (
        .core_clk(core_clk), .srst(srst), .qEventLatch(cmd[0]), .qEventMask(cmd[1]),
        .qRequestMask(cmd[2]), .qStatusByte(cmd[3]), .qStateWord(cmd[4]), .serialPoll(cmd[5]),
        .wEventMask(cmd[6]), .wRequestMask(cmd[7]), .wData(wData), .clearStatus(cmd[8]),
        .deviceClear(cmd[9]), .resetCmd(cmd[10]), .eventIn(eventIn), .malformedCmd(malformedCmd),
        .remoteIdle(remoteIdle), .outputPending(outputPending), .errorPending(errorPending),
        .stateChangeLatch(stateChangeLatch), .stateChangeMask(stateChangeMask),
        .instrumentState(instrumentState), .respData(respData), .respValid(respValid),
        .serviceRequest(serviceRequest), .masterSummary(masterSummary), .srqO(srqO), .srqOe(srqOe)
    );
    ssr_ctrl_model u_ctrl (
        .core_clk(core_clk), .srqO(srqO), .srqOe(srqOe), .strobes(cmd), .wData(wData), .srqLine(srqLine)
    );

    task automatic check(input ssr_word_t seen, input ssr_word_t exp, input string what);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Summary byte sources, bit 6 left for the caller to fill
    function automatic ssr_byte_t srcBits();
        return {remoteIdle, 1'b0, |(mLatch & mEvMask), outputPending, errorPending,
                |(stateChangeLatch & stateChangeMask), 2'b00};
    endfunction

    // Reference model, stepped on the same edge as the design
    always @(posedge core_clk) begin
        ssr_byte_t g;
        logic      clr;
        g      = srcBits() & mRqMask;
        clr    = cmd[8] | cmd[9] | cmd[10];
        mValid = 1'b1;
        if (cmd[5]) mData = {8'h00, srcBits() | {1'b0, mFlag, 6'h00}};
        else if (cmd[3]) mData = {8'h00, srcBits() | {1'b0, |g, 6'h00}};
        else if (cmd[0]) begin
            mData = {8'h00, mLatch};
            clr   = 1'b1;
        end
        else if (cmd[1]) mData = {8'h00, mEvMask};
        else if (cmd[2]) mData = {8'h00, mRqMask};
        else if (cmd[4]) mData = {8'h00, instrumentState};
        else mValid = 1'b0;
        if (|(g & ~mPrev)) mFlag = 1'b1;
        else if (cmd[5] | cmd[8] | ~|g) mFlag = 1'b0;
        mPrev  = g;
        // A new event wins over a clear in the same cycle
        mLatch = (clr ? 8'h00 : mLatch) | eventIn | {2'b00, malformedCmd, 5'h00};
        if (cmd[6]) mEvMask = wData[7:0];
        if (cmd[7]) mRqMask = wData[7:0] & 8'h3c;
        if (srst) begin
            {mLatch, mEvMask, mRqMask, mPrev, mFlag, mValid} = '0;
            mData = 16'h0000;
        end
    end

    // Ceiling well above the few thousand cycles the sequence needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 20000) begin
            bad_count++;
            results();
        end
    end

    // Compared well after the edge so design and model have both settled
    always @(posedge core_clk) begin
        #8;
        if (!srst) begin
            check(respValid, mValid, "respValid");
            if (mValid) check(respData, mData, "respData");
            check(serviceRequest, mFlag, "serviceRequest");
            check(srqLine, !mFlag, "srqLine");
            check(masterSummary, |(srcBits() & mRqMask), "masterSummary");
        end
    end

    // Random instrument conditions; events are kept sparse so the latch is not always full
    always @(negedge core_clk) begin
        if (randOn) begin
            eventIn          = $random(seed) & $random(seed) & $random(seed);
            malformedCmd     = ($random(seed) & 7) == 0;
            {remoteIdle, outputPending, errorPending} = $random(seed);
            stateChangeLatch = $random(seed) & $random(seed);
            stateChangeMask  = $random(seed);
            instrumentState  = $random(seed);
        end
    end

    initial begin
        repeat (4) @(negedge core_clk);
        srst = 1'b0;
        check(respData, 16'h0000, "respData after reset");
        u_ctrl.issue(11'h004, 16'h0000);
        u_ctrl.issue(11'h040, 16'h0021);
        u_ctrl.issue(11'h002, 16'h0000);
        u_ctrl.issue(11'h002, 16'h0000);
        malformedCmd = 1'b1;
        u_ctrl.issue(11'h001, 16'h0000);
        malformedCmd = 1'b0;
        u_ctrl.issue(11'h001, 16'h0000);
        u_ctrl.issue(11'h080, 16'hffff);
        u_ctrl.issue(11'h004, 16'h0000);
        outputPending = 1'b1;
        repeat (3) @(negedge core_clk);
        u_ctrl.issue(11'h020, 16'h0000);
        // Several queries at once: only the poll is served and the latch is kept
        u_ctrl.issue(11'h029, 16'h0000);
        outputPending = 1'b0;
        u_ctrl.issue(11'h008, 16'h0000);
        instrumentState = 8'ha5;
        u_ctrl.issue(11'h010, 16'h0000);
        randOn = 1'b1;
        repeat (1500) u_ctrl.issue(11'h001 << ({$random(seed)} % 11), ssr_word_t'($random(seed)));
        randOn = 1'b0;
        // Reset again mid-run: masks written at random must come back cleared
        srst = 1'b1;
        repeat (2) @(negedge core_clk);
        srst = 1'b0;
        check(respData, 16'h0000, "respData after second reset");
        u_ctrl.issue(11'h004, 16'h0000);
        u_ctrl.issue(11'h002, 16'h0000);
        results();
    end
endmodule // tb_top
